// File: rtl/eli_cfg.svh
/*
 * constants of the e1 line interrupt status block: register indices,
 * field positions, masks, reset values and bus response codes.
 * assumes it is included by the package before any use.
 */
`ifndef ELI_CFG_SVH
`define ELI_CFG_SVH

`define ELI_IDX_ENABLE      8'h34
`define ELI_IDX_FLAGS       8'h3b
`define ELI_IDX_CNT_HIGH    8'h3c
`define ELI_IDX_CNT_LOW     8'h3d
`define ELI_IDX_LINE_SUM    8'h3f
`define ELI_IDX_FRAME_SUM   8'h40
`define ELI_IDX_HDLC_SUM    8'h41
`define ELI_IDX_CLEAR       8'h50

`define ELI_ADDR_W          12
`define ELI_BIT_PSO         6
`define ELI_BIT_TXJ         5
`define ELI_BIT_RXJ         4
`define ELI_BIT_EXZ         2
`define ELI_BIT_CV          1
`define ELI_BIT_CNTOV       0
`define ELI_FLAG_MASK       8'h77
`define ELI_LINE_SUM_BIT    0

`define ELI_RST_FLAGS       8'h00
`define ELI_RST_ENABLE      8'h00
`define ELI_RST_COUNT       16'h0000
`define ELI_COUNT_MAX       16'hffff

`define ELI_RESP_OKAY       2'h0
`define ELI_RESP_SLVERR     2'h2

`endif

// File: rtl/eli_pkg.sv
/*
 * types shared by the line interrupt block and its bus slave.
 * assumes eli_cfg.svh is on the include path.
 */
`include "eli_cfg.svh"

package eli_pkg;

	typedef enum logic [2:0] {
		ELI_RD_IDLE  = 3'h1,
		ELI_RD_FETCH = 3'h2,
		ELI_RD_RESP  = 3'h4
	} eli_rd_e;

	typedef struct packed {
		logic       valid;
		logic [7:0] idx;
		logic [7:0] data;
	} eli_wr_s;

	typedef struct packed {
		logic       aw_got;
		logic       w_got;
		logic [7:0] aw_idx;
		logic       aw_bad;
		logic [7:0] wdata;
		logic       wstrb0;
		logic       awready;
		logic       wready;
		logic       bvalid;
		logic [1:0] bresp;
		eli_rd_e    rd_st;
		logic       arready;
		logic [7:0] ar_idx;
		logic       ar_bad;
		logic       rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		eli_wr_s    wr;
	} eli_axs_s;

	typedef struct packed {
		logic [7:0]  flags;
		logic [7:0]  enable;
		logic [15:0] count;
		logic        line_sum;
		logic [5:0]  frame_sum;
		logic [7:0]  hdlc_sum;
		logic        irq;
	} eli_top_s;

	function automatic logic eli_idx_hit(input logic [7:0] idx);
		case (idx)
			`ELI_IDX_ENABLE, `ELI_IDX_FLAGS, `ELI_IDX_CNT_HIGH, `ELI_IDX_CNT_LOW,
			`ELI_IDX_LINE_SUM, `ELI_IDX_FRAME_SUM, `ELI_IDX_HDLC_SUM,
			`ELI_IDX_CLEAR: eli_idx_hit = 1'b1;
			default: eli_idx_hit = 1'b0;
		endcase
	endfunction

endpackage

// File: rtl/eli_axil_slave.sv
/*
 * axi4-lite slave for the line interrupt registers: one write and one read
 * at a time, byte address is four times the register index.
 * assumes the owner answers rd_data combinationally from rd_idx.
 */
`timescale 1ns/10ps

module eli_axil_slave
	import eli_pkg::*;
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [`ELI_ADDR_W-1:0] s_awaddr,
	input  wire logic                  s_awvalid,
	output logic                       s_awready,
	input  wire logic [31:0]           s_wdata,
	input  wire logic [3:0]            s_wstrb,
	input  wire logic                  s_wvalid,
	output logic                       s_wready,
	output logic [1:0]                 s_bresp,
	output logic                       s_bvalid,
	input  wire logic                  s_bready,
	input  wire logic [`ELI_ADDR_W-1:0] s_araddr,
	input  wire logic                  s_arvalid,
	output logic                       s_arready,
	output logic [31:0]                s_rdata,
	output logic [1:0]                 s_rresp,
	output logic                       s_rvalid,
	input  wire logic                  s_rready,
	output eli_wr_s                    wr,
	output logic [7:0]                 rd_idx,
	input  wire logic [7:0]            rd_data
);

	eli_axs_s q;
	eli_axs_s d;

	always_comb begin
		d = q;
		d.wr.valid = 1'b0;
		if (q.awready && s_awvalid) begin
			d.aw_got = 1'b1;
			d.aw_idx = s_awaddr[9:2];
			d.aw_bad = (s_awaddr[11:10] != 2'h0) || !eli_idx_hit(s_awaddr[9:2]);
		end
		if (q.wready && s_wvalid) begin
			d.w_got  = 1'b1;
			d.wdata  = s_wdata[7:0];
			d.wstrb0 = s_wstrb[0];
		end
		// answer only once both halves are held, in whichever order they came
		if (q.aw_got && q.w_got && !q.bvalid) begin
			d.aw_got   = 1'b0;
			d.w_got    = 1'b0;
			d.bvalid   = 1'b1;
			d.bresp    = q.aw_bad ? `ELI_RESP_SLVERR : `ELI_RESP_OKAY;
			d.wr.valid = !q.aw_bad && q.wstrb0;
			d.wr.idx   = q.aw_idx;
			d.wr.data  = q.wdata;
		end
		if (q.bvalid && s_bready) begin
			d.bvalid = 1'b0;
		end
		d.awready = !d.aw_got && !d.bvalid;
		d.wready  = !d.w_got && !d.bvalid;

		case (q.rd_st)
			ELI_RD_IDLE: begin
				if (q.arready && s_arvalid) begin
					d.ar_idx = s_araddr[9:2];
					d.ar_bad = (s_araddr[11:10] != 2'h0) || !eli_idx_hit(s_araddr[9:2]);
					d.rd_st  = ELI_RD_FETCH;
				end
			end
			ELI_RD_FETCH: begin
				// unmapped reads return zero with an error
				d.rdata  = q.ar_bad ? 32'h0000_0000 : {24'h00_0000, rd_data};
				d.rresp  = q.ar_bad ? `ELI_RESP_SLVERR : `ELI_RESP_OKAY;
				d.rvalid = 1'b1;
				d.rd_st  = ELI_RD_RESP;
			end
			ELI_RD_RESP: begin
				if (s_rready) begin
					d.rvalid = 1'b0;
					d.rd_st  = ELI_RD_IDLE;
				end
			end
			default: begin
				d.rvalid = 1'b0;
				d.rd_st  = ELI_RD_IDLE;
			end
		endcase
		d.arready = (d.rd_st == ELI_RD_IDLE);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q       <= '0;
			q.rd_st <= ELI_RD_IDLE;
		end else begin
			q <= d;
		end
	end

	assign s_awready = q.awready;
	assign s_wready  = q.wready;
	assign s_bvalid  = q.bvalid;
	assign s_bresp   = q.bresp;
	assign s_arready = q.arready;
	assign s_rvalid  = q.rvalid;
	assign s_rdata   = q.rdata;
	assign s_rresp   = q.rresp;
	assign wr        = q.wr;
	assign rd_idx    = q.ar_idx;

endmodule // eli_axil_slave

// File: rtl/eli_line_irq.sv
/*
 * e1 line interrupt status: sticky line event flags with enables, the
 * excessive zero error counter, block summary registers and the irq output.
 * assumes event and block interrupt inputs come from logic on aclk.
 */
`timescale 1ns/10ps

module eli_line_irq
	import eli_pkg::*;
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [`ELI_ADDR_W-1:0] s_awaddr,
	input  wire logic                  s_awvalid,
	output logic                       s_awready,
	input  wire logic [31:0]           s_wdata,
	input  wire logic [3:0]            s_wstrb,
	input  wire logic                  s_wvalid,
	output logic                       s_wready,
	output logic [1:0]                 s_bresp,
	output logic                       s_bvalid,
	input  wire logic                  s_bready,
	input  wire logic [`ELI_ADDR_W-1:0] s_araddr,
	input  wire logic                  s_arvalid,
	output logic                       s_arready,
	output logic [31:0]                s_rdata,
	output logic [1:0]                 s_rresp,
	output logic                       s_rvalid,
	input  wire logic                  s_rready,
	input  wire logic                  pulse_sum_overflow_evt,
	input  wire logic                  tx_jitter_fifo_slip_evt,
	input  wire logic                  rx_jitter_fifo_slip_evt,
	input  wire logic                  excess_zero_evt,
	input  wire logic                  code_violation_evt,
	input  wire logic [5:0]            framing_block_irq,
	input  wire logic [7:0]            hdlc_sysif_block_irq,
	output logic                       irq
);

	eli_top_s   q;
	eli_top_s   d;
	eli_wr_s    wr;
	logic [7:0] rd_idx;
	logic [7:0] rd_data;
	logic [7:0] set_vec;
	logic [7:0] clr_vec;

	eli_axil_slave u_bus (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.s_awaddr  (s_awaddr),
		.s_awvalid (s_awvalid),
		.s_awready (s_awready),
		.s_wdata   (s_wdata),
		.s_wstrb   (s_wstrb),
		.s_wvalid  (s_wvalid),
		.s_wready  (s_wready),
		.s_bresp   (s_bresp),
		.s_bvalid  (s_bvalid),
		.s_bready  (s_bready),
		.s_araddr  (s_araddr),
		.s_arvalid (s_arvalid),
		.s_arready (s_arready),
		.s_rdata   (s_rdata),
		.s_rresp   (s_rresp),
		.s_rvalid  (s_rvalid),
		.s_rready  (s_rready),
		.wr        (wr),
		.rd_idx    (rd_idx),
		.rd_data   (rd_data)
	);

	always_comb begin
		d       = q;
		set_vec = 8'h00;
		clr_vec = 8'h00;

		set_vec[`ELI_BIT_PSO] = pulse_sum_overflow_evt;
		set_vec[`ELI_BIT_TXJ] = tx_jitter_fifo_slip_evt;
		set_vec[`ELI_BIT_RXJ] = rx_jitter_fifo_slip_evt;
		set_vec[`ELI_BIT_EXZ] = excess_zero_evt;
		set_vec[`ELI_BIT_CV]  = code_violation_evt;

		// counter wraps to zero; the wrap itself is the overflow event
		if (excess_zero_evt) begin
			d.count = q.count + 16'h0001;
			set_vec[`ELI_BIT_CNTOV] = (q.count == `ELI_COUNT_MAX);
		end

		if (wr.valid && (wr.idx == `ELI_IDX_FLAGS || wr.idx == `ELI_IDX_CLEAR)) begin
			clr_vec = wr.data;
		end
		if (wr.valid && wr.idx == `ELI_IDX_ENABLE) begin
			d.enable = wr.data & `ELI_FLAG_MASK;
		end

		// a new event in the clearing cycle survives the clear
		d.flags = ((q.flags & ~clr_vec) | set_vec) & `ELI_FLAG_MASK;

		d.line_sum  = |(q.flags & q.enable);
		d.frame_sum = framing_block_irq;
		d.hdlc_sum  = hdlc_sysif_block_irq;
		d.irq       = d.line_sum | (|framing_block_irq) | (|hdlc_sysif_block_irq);
	end

	always_comb begin
		rd_data = 8'h00;
		case (rd_idx)
			`ELI_IDX_ENABLE:    rd_data = q.enable;
			`ELI_IDX_FLAGS:     rd_data = q.flags;
			`ELI_IDX_CNT_HIGH:  rd_data = q.count[15:8];
			`ELI_IDX_CNT_LOW:   rd_data = q.count[7:0];
			`ELI_IDX_LINE_SUM:  rd_data[`ELI_LINE_SUM_BIT] = q.line_sum;
			`ELI_IDX_FRAME_SUM: rd_data = {2'h0, q.frame_sum};
			`ELI_IDX_HDLC_SUM:  rd_data = q.hdlc_sum;
			default:            rd_data = 8'h00;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q        <= '0;
			q.flags  <= `ELI_RST_FLAGS;
			q.enable <= `ELI_RST_ENABLE;
			q.count  <= `ELI_RST_COUNT;
		end else begin
			q <= d;
		end
	end

	assign irq = q.irq;

endmodule // eli_line_irq

// File: verification/eli_line_irq_asserts.sv
/* bus timing and irq checks on the line interrupt block ports
   assumes binding onto eli_line_irq, all ports on aclk */
`timescale 1ns/10ps
module eli_line_irq_asserts import eli_pkg::*; (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_awvalid,
	input wire logic        s_awready,
	input wire logic        s_wvalid,
	input wire logic        s_wready,
	input wire logic        s_bvalid,
	input wire logic        s_bready,
	input wire logic        s_arvalid,
	input wire logic        s_arready,
	input wire logic        s_rvalid,
	input wire logic        s_rready,
	input wire logic [31:0] s_rdata,
	input wire logic [5:0]  framing_block_irq,
	input wire logic [7:0]  hdlc_sysif_block_irq,
	input wire logic        irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence ar_take; s_arvalid && s_arready; endsequence
	sequence w_take; s_awvalid && s_awready && s_wvalid && s_wready; endsequence
	a_rd_latency: assert property (ar_take |=> !s_rvalid ##1 s_rvalid)
		else $error("read answer off");
	a_wr_latency: assert property (w_take |=> !s_bvalid ##1 s_bvalid)
		else $error("write answer off");
	a_b_once: assert property (s_bvalid && s_bready |=> !s_bvalid)
		else $error("bvalid stuck");
	a_r_once: assert property (s_rvalid && s_rready |=> !s_rvalid)
		else $error("rvalid stuck");
	a_rd_upper: assert property (s_rvalid |-> s_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_reset_quiet: assert property ($rose(aresetn) |-> !irq && !s_bvalid && !s_rvalid)
		else $error("outputs busy after reset");
	a_frame_irq: assert property (|framing_block_irq |=> irq)
		else $error("framing irq lost");
	a_hdlc_irq: assert property (|hdlc_sysif_block_irq |=> irq)
		else $error("hdlc irq lost");
endmodule // eli_line_irq_asserts

bind eli_line_irq eli_line_irq_asserts u_chk (.*);

// File: verification/eli_line_irq_tb_top.sv
/* self-checking bench: axi4-lite tasks, event pulses, read and write response scoreboard
   assumes design files and checker compiled first */
`timescale 1ns/10ps
module eli_line_irq_tb_top import eli_pkg::*;;
	logic aclk = 0, aresetn = 0, irq;
	logic [11:0] s_awaddr = '0, s_araddr = '0;
	logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
	logic [31:0] s_wdata = '0, s_rdata;
	logic [3:0] s_wstrb = 4'hf;
	logic [1:0] s_bresp, s_rresp;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [4:0] ev = '0;
	logic [5:0] fb = '0;
	logic [7:0] hb = '0;
	logic [13:0] m;
	logic [33:0] qr[$];
	logic [1:0] qb[$];
	logic [7:0] idx[8] = '{8'h34, 8'h3b, 8'h3c, 8'h3d, 8'h3f, 8'h40, 8'h41, 8'h50};
	int bp[5] = '{6, 5, 4, 2, 1};
	int error_cnt = 0, n_compared = 0, seed = 76, i, n;

	always #10 aclk = ~aclk;

	eli_line_irq uut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
		.s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
		.s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
		.pulse_sum_overflow_evt(ev[0]), .tx_jitter_fifo_slip_evt(ev[1]),
		.rx_jitter_fifo_slip_evt(ev[2]), .excess_zero_evt(ev[3]),
		.code_violation_evt(ev[4]), .framing_block_irq(fb), .hdlc_sysif_block_irq(hb), .irq);

	task automatic chk_rd(input logic [33:0] e, input logic [33:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD read exp %h got %h", e, g);
		end
	endtask

	task automatic chk_b(input logic [1:0] e, input logic [1:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD bresp exp %h got %h", e, g);
		end
	endtask

	task automatic chk_irq(input logic e);
		n_compared++;
		if (irq !== e) begin
			error_cnt++;
			$display("BAD irq exp %b got %b", e, irq);
		end
	endtask

	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// scoreboard: oldest note against each answer
	always @(posedge aclk) begin
		if (s_rvalid && s_rready)
			chk_rd(qr.pop_front(), {s_rresp, s_rdata});
		if (s_bvalid && s_bready)
			chk_b(qb.pop_front(), s_bresp);
	end

	task automatic wr(input logic [7:0] x, input logic [7:0] d, input logic [1:0] r = 2'h0);
		int k;
		qb.push_back(r);
		s_awaddr <= {2'h0, x, 2'h0};
		s_wdata <= {24'h0, d};
		s_awvalid <= 1;
		s_wvalid <= 1;
		s_bready <= 1;
		for (k = 0; !(k > 0 && s_bvalid); k++) begin
			@(posedge aclk);
			if (s_awready) s_awvalid <= 0;
			if (s_wready) s_wvalid <= 0;
			if (k > 60) begin error_cnt++; conclude(); end
		end
		s_bready <= 0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] x, input logic [7:0] d, input logic [1:0] r = 2'h0);
		int k;
		qr.push_back({r, 24'h0, d});
		s_araddr <= {2'h0, x, 2'h0};
		s_arvalid <= 1;
		s_rready <= 1;
		for (k = 0; !(k > 0 && s_rvalid); k++) begin
			@(posedge aclk);
			if (s_arready) s_arvalid <= 0;
			if (k > 60) begin error_cnt++; conclude(); end
		end
		s_rready <= 0;
		@(posedge aclk);
	endtask

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		repeat (2) @(posedge aclk);
		foreach (idx[j]) rd(idx[j], 8'h00);
		rd(8'h42, 8'h00, 2'h2);
		wr(8'h42, 8'h01, 2'h2);
		wr(8'h3c, 8'hff);
		rd(8'h3c, 8'h00);
		// byte lane 0 off: answered okay, nothing written
		s_wstrb <= 4'he;
		wr(8'h34, 8'hff);
		s_wstrb <= 4'hf;
		rd(8'h34, 8'h00);
		$display("regs done");
		for (i = 0; i < 5; i++) begin
			ev <= 5'h1 << i;
			@(posedge aclk);
			ev <= 5'h0;
			rd(8'h3b, 8'(1 << bp[i]));
			chk_irq(1'b0);
			wr(8'h3b, 8'(1 << bp[i]));
			rd(8'h3b, 8'h00);
		end
		n = 2 + ($random(seed) & 15);
		ev <= 5'h08;
		repeat (n) @(posedge aclk);
		ev <= 5'h12;
		@(posedge aclk);
		ev <= 5'h0;
		rd(8'h3d, 8'(n + 1));
		rd(8'h3c, 8'h00);
		wr(8'h3b, 8'h20);
		rd(8'h3b, 8'h06);
		wr(8'h50, 8'h06);
		rd(8'h3b, 8'h00);
		$display("flags done");
		wr(8'h34, 8'hff);
		rd(8'h34, 8'h77);
		ev <= 5'h01;
		@(posedge aclk);
		ev <= 5'h0;
		repeat (3) @(posedge aclk);
		chk_irq(1'b1);
		rd(8'h3f, 8'h01);
		wr(8'h34, 8'h00);
		repeat (3) @(posedge aclk);
		chk_irq(1'b0);
		// event lands in the clearing cycle: the set has to survive
		fork
			wr(8'h3b, 8'h40);
			begin
				repeat (2) @(posedge aclk);
				ev <= 5'h01;
				@(posedge aclk);
				ev <= 5'h0;
			end
		join
		rd(8'h3b, 8'h40);
		wr(8'h3b, 8'h40);
		$display("irq done");
		// wrap takes a full 16-bit sweep
		ev <= 5'h08;
		repeat (65534 - n) @(posedge aclk);
		ev <= 5'h0;
		rd(8'h3c, 8'hff);
		rd(8'h3d, 8'hff);
		ev <= 5'h08;
		@(posedge aclk);
		ev <= 5'h0;
		rd(8'h3d, 8'h00);
		rd(8'h3b, 8'h05);
		$display("counter done");
		for (i = 0; i < 18; i++) begin
			m = (i < 14) ? 14'h1 << i : 14'($random(seed));
			{hb, fb} <= m;
			repeat (3) @(posedge aclk);
			chk_irq(|m);
			rd(8'h40, {2'h0, m[5:0]});
			rd(8'h41, m[13:6]);
		end
		{hb, fb} <= '0;
		repeat (3) @(posedge aclk);
		chk_irq(1'b0);
		$display("summary done");
		conclude();
	end
endmodule // eli_line_irq_tb_top
